//--- logic/xinsn_pkg.sv
package xinsn_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int DADDR_W = 12;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 21;
  localparam int WORD_W  = 16;
  localparam int AXI_AW  = 8;
  localparam int NUM_PTR = 3;
  localparam int SSP_IDX = 2;

  // ----------------------------------------
  // opcode patterns
  // ----------------------------------------
  localparam logic [8:0] OP_MOVE_FIRST = 9'h1D7;  // 1110 1011 1
  localparam logic [7:0] OP_PUSH       = 8'hFA;   // 1111 1010
  localparam logic [7:0] OP_SUB_PTR    = 8'hE9;   // 1110 1001
  localparam logic [1:0] SEL_RETURN    = 2'h3;

  // ----------------------------------------
  // file address mapping
  // ----------------------------------------
  localparam logic [7:0] OFFSET_BOUND = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h7F;
  localparam logic [3:0] ACCESS_HIGH  = 4'hF;

  // ----------------------------------------
  // register map and reset values
  // ----------------------------------------
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_PTR0    = 8'h04;
  localparam logic [7:0]  REG_PTR1    = 8'h08;
  localparam logic [7:0]  REG_SSP     = 8'h0C;
  localparam logic [7:0]  REG_STATUS  = 8'h10;
  localparam int          CTRL_EXT    = 0;
  localparam logic        EXT_RESET   = 1'b0;
  localparam logic [11:0] PTR_RESET   = 12'h000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_MOVE2   = 3'b010,
    ST_RET_NOP = 3'b100
  } exec_state_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] file_addr;
    logic       access;
    logic       dest;
  } std_op_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic        to_file;
  } std_addr_t;

endpackage

//--- logic/ptr_offset_calc.sv
`timescale 1ns/1ps
module ptr_offset_calc #(
  parameter logic [11:0] INDIRECT_LO = 12'hFD8,
  parameter logic [11:0] INDIRECT_HI = 12'hFEF
) (
  // operands
  input  logic [11:0] base,
  input  logic [6:0]  offset,
  // result
  output logic [11:0] addr,
  output logic        indirect
);

  // sum is kept at data address width, so it wraps inside the data space
  assign addr     = base + {5'h00, offset};
  assign indirect = (addr >= INDIRECT_LO) && (addr <= INDIRECT_HI);

endmodule

//--- logic/file_addr_map.sv
`timescale 1ns/1ps
module file_addr_map (
  // clock and reset
  input  logic                ref_clk,
  input  logic                sys_rst,
  // mode and pointers
  input  logic                ext_enable,
  input  logic [11:0]         ssp,
  input  logic [3:0]          bank_sel,
  // operand in, address out
  input  xinsn_pkg::std_op_t  op_in,
  output xinsn_pkg::std_addr_t addr_out
);

  logic [11:0] addr_d;

  // one mapping for every byte and bit instruction that has the access bit
  always_comb begin
    if (op_in.access) begin
      addr_d = {bank_sel, op_in.file_addr};
    end else if (ext_enable && op_in.file_addr <= xinsn_pkg::OFFSET_BOUND) begin
      addr_d = ssp + {4'h0, op_in.file_addr};
    end else if (op_in.file_addr > xinsn_pkg::ACCESS_SPLIT) begin
      addr_d = {xinsn_pkg::ACCESS_HIGH, op_in.file_addr};
    end else begin
      addr_d = {4'h0, op_in.file_addr};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addr_out <= '0;
    end else begin
      addr_out.valid   <= op_in.valid;
      addr_out.addr    <= addr_d;
      addr_out.to_file <= op_in.dest;
    end
  end

  remap_offset_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    op_in.valid && ext_enable && !op_in.access && op_in.file_addr <= 8'h5F
    |=> addr_out.addr == 12'($past(ssp) + {4'h0, $past(op_in.file_addr)}))
    else $error("offset access not relative to stack pointer");

  keep_absolute_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    op_in.valid && !op_in.access && op_in.file_addr > 8'h5F
    |=> addr_out.addr[7:0] == $past(op_in.file_addr))
    else $error("absolute access bank address altered");

  dest_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    op_in.valid |=> addr_out.valid && addr_out.to_file == $past(op_in.dest))
    else $error("destination bit changed");

  zero_compat_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    op_in.valid && !op_in.access && ssp == 12'h000 && op_in.file_addr <= 8'h7F
    |=> addr_out.addr == {4'h0, $past(op_in.file_addr)})
    else $error("zero pointer does not match access bank");

  banked_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    op_in.valid && op_in.access |=> addr_out.addr == {$past(bank_sel), $past(op_in.file_addr)})
    else $error("banked access wrong");

endmodule

//--- logic/xinsn_exec.sv
// Behaviour
// - indexed move is two words; read source first cycle, write destination second
// - move addresses are stack pointer plus separate 7-bit offsets
// - source hitting an indirect register reads as zero
// - destination hitting an indirect register makes the move a no-op
// - push literal stores at stack pointer then decrements it by one
// - push literal decoded from fixed upper byte, finishes in one cycle
// - subtract 6-bit literal from pointer selected zero to two, one cycle
// - subtract decoded from fixed upper bits, two selector bits, six literal bits
// - selector three subtracts from stack pointer, returns, second cycle idle
// - extended set off: access bank when bit clear, else bank select
// - extended set enable also turns on offset addressing
// - extended, access bit clear, address up to 5Fh is pointer offset
// - addresses above 5Fh keep absolute meaning
// - remapping covers every byte and bit instruction with access bit
// - destination bit keeps its meaning under offset addressing
// - stack pointer zero maps offsets to original access bank
// - extended set enable resets to disabled
`timescale 1ns/1ps
module xinsn_exec #(
  parameter logic [11:0] INDIRECT_LO = 12'hFD8,
  parameter logic [11:0] INDIRECT_HI = 12'hFEF
) (
  // clock and reset
  input  logic                    ref_clk,
  input  logic                    sys_rst,
  // register bus
  input  logic                    awvalid,
  output logic                    awready,
  input  logic [7:0]              awaddr,
  input  logic                    wvalid,
  output logic                    wready,
  input  logic [31:0]             wdata,
  input  logic [3:0]              wstrb,
  output logic                    bvalid,
  input  logic                    bready,
  output logic [1:0]              bresp,
  input  logic                    arvalid,
  output logic                    arready,
  input  logic [7:0]              araddr,
  output logic                    rvalid,
  input  logic                    rready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  // instruction stream
  input  logic                    insn_valid,
  output logic                    insn_ready,
  input  logic [15:0]             insn_word,
  // data memory, read data combinational from addr
  output xinsn_pkg::mem_req_t     mem_req,
  input  logic [7:0]              mem_rdata,
  // return stack and program counter
  input  logic [20:0]             return_stack_top,
  output logic                    pc_load,
  output logic [20:0]             pc_load_value,
  // standard instruction addressing
  input  logic [3:0]              bank_select_reg,
  input  xinsn_pkg::std_op_t      std_op,
  output xinsn_pkg::std_addr_t    std_addr
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  xinsn_pkg::exec_state_t state_q;
  logic                   ext_q;
  logic [11:0]            ptr_q [xinsn_pkg::NUM_PTR];
  xinsn_pkg::mem_req_t    mem_req_q;
  xinsn_pkg::mem_req_t    mem_req_d;
  logic                   src_ind_q;
  logic                   src_fresh_q;
  logic [7:0]             src_data_q;
  logic                   pc_load_q;
  logic [20:0]            pc_value_q;
  logic                   bvalid_q;
  logic [1:0]             bresp_q;
  logic                   rvalid_q;
  logic [31:0]            rdata_q;
  logic [1:0]             rresp_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic        insn_take;
  logic        idle;
  logic        is_move1;
  logic        is_push;
  logic        is_sub;
  logic        is_ret;
  logic        is_move2;
  logic [1:0]  sub_sel;
  logic [5:0]  sub_lit;
  logic [11:0] ssp;
  logic [11:0] src_addr;
  logic [11:0] dst_addr;
  logic        src_ind;
  logic        dst_ind;
  logic [7:0]  move_data;

  assign ssp        = ptr_q[xinsn_pkg::SSP_IDX];
  assign idle       = (state_q == xinsn_pkg::ST_IDLE);
  // the return's idle cycle stalls the fetch side
  assign insn_ready = (state_q != xinsn_pkg::ST_RET_NOP);
  assign insn_take  = insn_valid && insn_ready;
  // extended opcodes are only ours while the enable is set; otherwise the core owns them
  assign is_move1   = idle && ext_q && insn_word[15:7] == xinsn_pkg::OP_MOVE_FIRST;
  assign is_push    = idle && ext_q && insn_word[15:8] == xinsn_pkg::OP_PUSH;
  assign is_sub     = idle && ext_q && insn_word[15:8] == xinsn_pkg::OP_SUB_PTR;
  assign sub_sel    = insn_word[7:6];
  assign sub_lit    = insn_word[5:0];
  assign is_ret     = is_sub && sub_sel == xinsn_pkg::SEL_RETURN;
  assign is_move2   = state_q == xinsn_pkg::ST_MOVE2;

  ptr_offset_calc #(
    .INDIRECT_LO (INDIRECT_LO),
    .INDIRECT_HI (INDIRECT_HI)
  ) u_src (
    .base     (ssp),
    .offset   (insn_word[6:0]),
    .addr     (src_addr),
    .indirect (src_ind)
  );

  ptr_offset_calc #(
    .INDIRECT_LO (INDIRECT_LO),
    .INDIRECT_HI (INDIRECT_HI)
  ) u_dst (
    .base     (ssp),
    .offset   (insn_word[6:0]),
    .addr     (dst_addr),
    .indirect (dst_ind)
  );

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= xinsn_pkg::ST_IDLE;
    end else begin
      case (state_q)
        xinsn_pkg::ST_IDLE: begin
          if (insn_take && is_move1) begin
            state_q <= xinsn_pkg::ST_MOVE2;
          end else if (insn_take && is_ret) begin
            state_q <= xinsn_pkg::ST_RET_NOP;
          end
        end
        xinsn_pkg::ST_MOVE2: begin
          if (insn_take) begin
            state_q <= xinsn_pkg::ST_IDLE;
          end
        end
        xinsn_pkg::ST_RET_NOP: state_q <= xinsn_pkg::ST_IDLE;
        default: state_q <= xinsn_pkg::ST_IDLE;
      endcase
    end
  end

  // source byte: live read data right after the read, held copy if the second word lags
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      src_ind_q   <= 1'b0;
      src_fresh_q <= 1'b0;
      src_data_q  <= 8'h00;
    end else begin
      if (insn_take && is_move1) begin
        src_ind_q <= src_ind;
      end
      src_fresh_q <= insn_take && is_move1;
      if (src_fresh_q) begin
        src_data_q <= mem_rdata;
      end
    end
  end

  assign move_data = src_ind_q   ? 8'h00 :
                     src_fresh_q ? mem_rdata : src_data_q;

  // ----------------------------------------
  // data memory requests
  // ----------------------------------------
  always_comb begin
    mem_req_d = '0;
    if (insn_take && is_move1) begin
      // an indirect register has side effects, so it is not read at all
      mem_req_d.rd   = !src_ind;
      mem_req_d.addr = src_addr;
    end else if (insn_take && is_push) begin
      mem_req_d.wr    = 1'b1;
      mem_req_d.addr  = ssp;
      mem_req_d.wdata = insn_word[7:0];
    end else if (insn_take && is_move2 && !dst_ind) begin
      mem_req_d.wr    = 1'b1;
      mem_req_d.addr  = dst_addr;
      mem_req_d.wdata = move_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_req_q <= '0;
    end else begin
      mem_req_q <= mem_req_d;
    end
  end

  assign mem_req = mem_req_q;

  // ----------------------------------------
  // return
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc_load_q  <= 1'b0;
      pc_value_q <= 21'h000000;
    end else begin
      pc_load_q <= insn_take && is_ret;
      if (insn_take && is_ret) begin
        pc_value_q <= return_stack_top;
      end
    end
  end

  assign pc_load       = pc_load_q;
  assign pc_load_value = pc_value_q;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic       wr_take;
  logic       ar_take;
  logic       wr_mapped;
  logic [7:0] ptr_offs [xinsn_pkg::NUM_PTR];

  assign ptr_offs[0] = xinsn_pkg::REG_PTR0;
  assign ptr_offs[1] = xinsn_pkg::REG_PTR1;
  assign ptr_offs[2] = xinsn_pkg::REG_SSP;

  // write address and data are taken together; the master holds each until then
  assign wr_take = awvalid && wvalid && !bvalid_q;
  assign awready = wr_take;
  assign wready  = wr_take;
  assign ar_take = arvalid && !rvalid_q;
  assign arready = !rvalid_q;
  assign wr_mapped = awaddr == xinsn_pkg::REG_CTRL || awaddr == xinsn_pkg::REG_PTR0 ||
                     awaddr == xinsn_pkg::REG_PTR1 || awaddr == xinsn_pkg::REG_SSP ||
                     awaddr == xinsn_pkg::REG_STATUS;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_q <= xinsn_pkg::EXT_RESET;
    end else if (wr_take && awaddr == xinsn_pkg::REG_CTRL && wstrb[0]) begin
      ext_q <= wdata[xinsn_pkg::CTRL_EXT];
    end
  end

  // the instruction stream wins a same-cycle clash with a bus write
  for (genvar i = 0; i < xinsn_pkg::NUM_PTR; i++) begin : g_ptr
    logic sub_hit;
    assign sub_hit = insn_take && is_sub &&
                     (sub_sel == 2'(i) || (i == xinsn_pkg::SSP_IDX && is_ret));
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        ptr_q[i] <= xinsn_pkg::PTR_RESET;
      end else if (sub_hit) begin
        ptr_q[i] <= ptr_q[i] - {6'h00, sub_lit};
      end else if (i == xinsn_pkg::SSP_IDX && insn_take && is_push) begin
        ptr_q[i] <= ptr_q[i] - 12'h001;
      end else if (wr_take && awaddr == ptr_offs[i]) begin
        if (wstrb[0]) ptr_q[i][7:0] <= wdata[7:0];
        if (wstrb[1]) ptr_q[i][11:8] <= wdata[11:8];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= xinsn_pkg::RESP_OKAY;
    end else if (wr_take) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? xinsn_pkg::RESP_OKAY : xinsn_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= xinsn_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= xinsn_pkg::RESP_OKAY;
      case (araddr)
        xinsn_pkg::REG_CTRL:   rdata_q <= {31'h00000000, ext_q};
        xinsn_pkg::REG_PTR0:   rdata_q <= {20'h00000, ptr_q[0]};
        xinsn_pkg::REG_PTR1:   rdata_q <= {20'h00000, ptr_q[1]};
        xinsn_pkg::REG_SSP:    rdata_q <= {20'h00000, ptr_q[2]};
        xinsn_pkg::REG_STATUS: rdata_q <= {28'h0000000, src_ind_q, state_q};
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= xinsn_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

  // ----------------------------------------
  // standard instruction addressing
  // ----------------------------------------
  file_addr_map u_map (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .ext_enable (ext_q),
    .ssp        (ssp),
    .bank_sel   (bank_select_reg),
    .op_in      (std_op),
    .addr_out   (std_addr)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  move_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    insn_take && is_move1 |=> mem_req.rd == !$past(src_ind) && !mem_req.wr &&
      mem_req.addr == 12'($past(ssp) + {5'h00, $past(insn_word[6:0])}))
    else $error("indexed move source read wrong");

  move_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    insn_take && is_move1 ##1 (insn_take && !dst_ind && !src_ind_q)
      |=> mem_req.wr && mem_req.wdata == $past(mem_rdata))
    else $error("indexed move did not write source byte");

  src_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_move2 && insn_take && src_ind_q && !dst_ind |=> mem_req.wr && mem_req.wdata == 8'h00)
    else $error("indirect source not read as zero");

  dst_nop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    is_move2 && insn_take && dst_ind |=> !mem_req.wr && !mem_req.rd)
    else $error("indirect destination was written");

  push_store_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    insn_take && is_push |=> mem_req.wr && mem_req.addr == $past(ssp) &&
      mem_req.wdata == $past(insn_word[7:0]) && ssp == 12'($past(ssp) - 12'h001))
    else $error("push literal store or decrement wrong");

  push_single_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    insn_take && is_push |=> insn_ready && state_q == xinsn_pkg::ST_IDLE)
    else $error("push literal took more than one cycle");

  sub_ptr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    insn_take && is_sub && sub_sel == 2'h0 |=> ptr_q[0] == 12'($past(ptr_q[0]) -
      {6'h00, $past(insn_word[5:0])}) && insn_ready)
    else $error("pointer subtract wrong");

  ret_seq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    insn_take && is_ret |=> (pc_load && pc_load_value == $past(return_stack_top) &&
      !insn_ready && ssp == 12'($past(ssp) - {6'h00, $past(insn_word[5:0])}))
      ##1 (insn_ready && !pc_load))
    else $error("subtract and return sequence wrong");

  ext_reset_a: assert property (@(posedge ref_clk)
    sys_rst |=> !ext_q)
    else $error("extended set enabled out of reset");

  ext_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !ext_q && state_q == xinsn_pkg::ST_IDLE |=> !mem_req.wr && !mem_req.rd && !pc_load)
    else $error("extended opcode ran while disabled");

endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [11:0] IND_LO = 12'hFD8;
  localparam logic [11:0] IND_HI = 12'hFEF;
  logic                 ref_clk = 1'h0, sys_rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0;
  logic                 bready = 1'h0, arvalid = 1'h0, rready = 1'h0, insn_valid = 1'h0;
  logic                 awready, wready, bvalid, arready, rvalid, insn_ready, pc_load;
  logic [7:0]           awaddr = 8'h00, araddr = 8'h00, mem_rdata;
  logic [31:0]          wdata = 32'h0, rdata;
  logic [3:0]           wstrb = 4'hF, bank_select_reg = 4'h0;
  logic [1:0]           bresp, rresp;
  logic [15:0]          insn_word = 16'h0000;
  logic [20:0]          return_stack_top = 21'h0, pc_load_value;
  xinsn_pkg::mem_req_t  mem_req;
  xinsn_pkg::std_op_t   std_op = '0;
  xinsn_pkg::std_addr_t std_addr;
  logic [11:0]          p [3] = '{12'h0, 12'h0, 12'h0};
  logic [33:0]          q_mem[$], q_pc[$], q_std[$], q_rd[$], q_b[$];
  logic                 ext = 1'h0;
  integer               seed = 28415;
  int                   error_cnt = 0, checks_done = 0, cyc = 0;

  always #12.5 ref_clk = ~ref_clk;
  // data memory answers in the same cycle, contents derived from the address
  assign mem_rdata = mem_req.addr[7:0] ^ 8'h5A;

  xinsn_exec #(.INDIRECT_LO(IND_LO), .INDIRECT_HI(IND_HI)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .insn_valid(insn_valid), .insn_ready(insn_ready),
    .insn_word(insn_word), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .return_stack_top(return_stack_top), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .bank_select_reg(bank_select_reg),
    .std_op(std_op), .std_addr(std_addr));

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // a result that arrives with no note waiting counts as a mismatch
  task automatic take(string nm, ref logic [33:0] q[$], input logic [33:0] g);
    chk(nm, (q.size() > 0) ? q.pop_front() : ~g, g);
  endtask

  always @(posedge ref_clk) begin
    if (!sys_rst) begin
      if (mem_req.wr !== 1'h0) take("mem_wr", q_mem, {mem_req.addr, mem_req.wdata});
      if (std_addr.valid !== 1'h0) take("std_addr", q_std, {std_addr.addr, std_addr.to_file});
      if (rvalid !== 1'h0 && rready) take("rdata", q_rd, {rresp, rdata});
      if (bvalid !== 1'h0 && bready) take("bresp", q_b, bresp);
      if (pc_load !== 1'h0) begin
        take("pc_load_value", q_pc, pc_load_value);
        chk("insn_ready", 34'h0, insn_ready);
      end
    end
  end

  task automatic finish_test();
    int left;
    // a note still waiting means an expected result never appeared
    left = q_mem.size() + q_pc.size() + q_std.size() + q_rd.size() + q_b.size();
    if (left != 0) begin
      error_cnt++;
      $display("BAD pending_notes expected 0 seen %0d", left);
    end
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic wr_reg(logic [7:0] a, logic [31:0] d, logic [1:0] r = xinsn_pkg::RESP_OKAY);
    @(posedge ref_clk);
    q_b.push_back(r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do @(posedge ref_clk); while (awready !== 1'h1);
    awvalid <= 1'h0;
    wvalid  <= 1'h0;
    do @(posedge ref_clk); while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask

  task automatic rd_reg(logic [7:0] a, logic [31:0] d, logic [1:0] r = xinsn_pkg::RESP_OKAY);
    @(posedge ref_clk);
    q_rd.push_back({r, d});
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do @(posedge ref_clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge ref_clk); while (rvalid !== 1'h1);
    rready <= 1'h0;
  endtask

  task automatic wr_ptr(int i, logic [11:0] v);
    p[i] = v;
    wr_reg(xinsn_pkg::REG_PTR0 + 8'(4 * i), {20'h0, v});
  endtask

  task automatic rd_ptrs();
    for (int i = 0; i < 3; i++) rd_reg(xinsn_pkg::REG_PTR0 + 8'(4 * i), {20'h0, p[i]});
  endtask

  // valid stays up between words so back-to-back words never toggle it
  task automatic issue(logic [15:0] w);
    insn_word  <= w;
    insn_valid <= 1'h1;
    do @(posedge ref_clk); while (insn_ready !== 1'h1);
  endtask

  task automatic idle();
    insn_valid <= 1'h0;
    @(posedge ref_clk);
  endtask

  function automatic logic ind(logic [11:0] a);
    return a >= IND_LO && a <= IND_HI;
  endfunction

  task automatic push_lit(logic [7:0] k);
    q_mem.push_back({p[2], k});
    p[2] = p[2] - 12'h001;
    issue({xinsn_pkg::OP_PUSH, k});
  endtask

  // gap idles one cycle between the words, so the held source copy is used
  task automatic move(logic [6:0] zs, logic [6:0] zd, logic gap = 1'h0);
    logic [11:0] sa, da;
    sa = p[2] + 12'(zs);
    da = p[2] + 12'(zd);
    if (!ind(da)) q_mem.push_back({da, ind(sa) ? 8'h00 : sa[7:0] ^ 8'h5A});
    issue({xinsn_pkg::OP_MOVE_FIRST, zs});
    if (gap) idle();
    issue({4'hF, 5'($random(seed)), zd});
  endtask

  task automatic sub(logic [1:0] sel, logic [5:0] k);
    logic [20:0] t;
    t = 21'($random(seed));
    if (sel == xinsn_pkg::SEL_RETURN) q_pc.push_back(t);
    return_stack_top <= t;
    p[(sel == xinsn_pkg::SEL_RETURN) ? 2 : sel] -= 12'(k);
    issue({xinsn_pkg::OP_SUB_PTR, sel, k});
  endtask

  task automatic sweep();
    logic [7:0]  ft [6] = '{8'h00, 8'h5F, 8'h60, 8'h7F, 8'h80, 8'h00};
    logic [3:0]  b;
    logic [7:0]  f;
    logic [11:0] e;
    logic        a, d;
    b = 4'($random(seed));
    bank_select_reg <= b;
    for (int i = 0; i < 12; i++) begin
      f = (i % 6 == 5) ? 8'($random(seed)) : ft[i % 6];
      a = 1'(i / 6);
      d = 1'($random(seed));
      e = a ? {b, f} : (ext && f <= 8'h5F) ? p[2] + 12'(f) : {(f > 8'h7F) ? 4'hF : 4'h0, f};
      q_std.push_back({e, d});
      std_op <= '{1'h1, f, a, d};
      @(posedge ref_clk);
    end
    std_op <= '0;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    rd_reg(xinsn_pkg::REG_CTRL, 32'h0);
    rd_reg(xinsn_pkg::REG_SSP, 32'h0);
    wr_reg(8'h40, 32'h1, xinsn_pkg::RESP_SLVERR);
    rd_reg(8'h40, 32'h0, xinsn_pkg::RESP_SLVERR);
    for (int i = 0; i < 3; i++) wr_ptr(i, 12'($random(seed)));
    issue({xinsn_pkg::OP_PUSH, 8'h5C});
    idle();
    sweep();
    rd_ptrs();
    $display("test disabled done");
    wr_reg(xinsn_pkg::REG_CTRL, 32'h1);
    ext = 1'h1;
    rd_reg(xinsn_pkg::REG_CTRL, 32'h1);
    wr_ptr(2, 12'h001);
    repeat (3) push_lit(8'($random(seed)));
    idle();
    rd_ptrs();
    $display("test push done");
    // random destinations stay at or below F7Eh, under the indirect registers from FD8h
    wr_ptr(2, 12'($random(seed)) & 12'hEFF);
    repeat (2) move(7'($random(seed)), 7'($random(seed)));
    idle();
    wr_ptr(2, 12'hF80);
    move(7'h58, 7'h00);
    move(7'h00, 7'h6F);
    idle();
    wr_ptr(2, 12'hFF0);
    move(7'h20, 7'h7F, 1'h1);
    idle();
    $display("test move done");
    for (int s = 0; s < 8; s++) sub(2'(s), (s < 4) ? 6'($random(seed)) : 6'h3F);
    push_lit(8'hA5);
    idle();
    rd_ptrs();
    $display("test subtract done");
    sweep();
    wr_ptr(2, 12'h000);
    sweep();
    $display("test addressing done");
    repeat (5) @(posedge ref_clk);
    finish_test();
  end
endmodule
